// file: hdl/mth_pdu_handler.sv
// Modbus server request handler: parses request PDUs and emits responses
// Behaviour
// - Serve code 01 reading outputs and code 02 reading inputs.
// - Serve code 03 marker words and code 04 analog input words.
// - Serve code 06 single write and code 10 multiple write.
// - First request byte is the function code selecting the operation.
// - Success response starts with the request function code.
// - Error frame is code plus 80 then the exception code.
// - Only answer requests; never start a transfer unasked.
// - Only requests to service port 502 are served.
// - Address and quantity fields arrive high byte first.
// - Bit reads ask for 1 to 2000 items.
// - Items read run from start address for the requested count.
// - Bit read answer: code, byte count, eight states per byte.
// - A state bit is one when on, zero when off.
// - First requested output sits in bit zero of first byte.
// - Input reads pack exactly like output reads.
// - Unused bits of the last state byte are zero.
// - Register reads ask for 1 to 125 registers.
// - Register read byte count is twice the register count.
// - Each register goes out high byte then low byte.
// - Bit zero of every byte is its least significant bit.
// - Any item outside the image gives exception 02.
// - Bad quantity gives exception 03.
// - A good single write is answered by an echo.
// - Multiple write asks 1 to 123 registers, byte count twice that.
`timescale 1ns/10ps
module mth_pdu_handler (
   input  wire logic                       i_sys_clk,   // Clock, 20 MHz
   input  wire logic                       i_nrst,      // Async reset, low
   input  wire logic                       i_ce,        // Clock enable
   input  wire mth_pkg::mth_beat_t         i_rx,        // Request byte
   input  wire logic                       i_rx_valid,  // Request byte valid
   output logic                            o_rx_ready,  // Request byte taken
   input  wire logic [15:0]                i_dst_port,  // Port of request
   output mth_pkg::mth_beat_t              o_tx,        // Response byte
   output logic                            o_tx_valid,  // Response byte valid
   input  wire logic                       i_tx_ready,  // Response byte taken
   input  wire logic [mth_pkg::BIT_W-1:0]  i_coil_img,  // Output states
   input  wire logic [mth_pkg::BIT_W-1:0]  i_din_img,   // Input states
   input  wire logic [mth_pkg::IREG_W*16-1:0] i_ireg_img // Analog words
);

   // Bound check: every item from a up to a+q-1 lies below lim
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] q,
                                     input logic [16:0] lim);
      in_range = ({1'b0, a} + {1'b0, q}) <= lim;
   endfunction

   // Packs eight states of byte k, zero past the quantity
   function automatic logic [7:0] pack_bits(input logic [mth_pkg::BIT_W-1:0] img,
                                            input logic [15:0] start,
                                            input logic [8:0]  k,
                                            input logic [15:0] qty);
      logic [15:0] pos;
      logic [15:0] idx;
      pack_bits = 8'h00;
      for (int j = 0; j < 8; j++) begin
         pos = {4'h0, k, 3'(j)};
         idx = start + pos;
         if (pos < qty && {1'b0, idx} < mth_pkg::COIL_N) begin
            pack_bits[j] = img[idx[4:0]];
         end
      end
   endfunction

   mth_pkg::mth_state_t st_ff;
   mth_pkg::mth_state_t nxt_st;
   mth_pkg::mth_req_t   req_ff;
   mth_pkg::mth_beat_t  tx_ff;
   logic [8:0]          rx_cnt_ff;
   logic                port_ok_ff;
   logic [7:0]          wr_hi_ff;
   logic [7:0]          exc_ff;
   logic [8:0]          len_ff;
   logic [8:0]          bi_ff;
   logic [8:0]          tx_idx_ff;
   logic                wait_ff;
   logic                tx_vld_ff;

   logic                rx_fire;
   logic                port_now;
   logic [7:0]          fc;
   logic                is_bit;
   logic                is_rreg;
   logic                is_one;
   logic                is_multi;
   logic                known;
   logic [16:0]         bit_lim;
   logic [16:0]         reg_lim;
   logic                qty_zero;
   logic [15:0]         qty2;
   logic                len_bad;
   logic                bad_qty;
   logic                bad_addr;
   logic [7:0]          exc_nxt;
   logic [15:0]         bcnt_w;
   logic [8:0]          len_nxt;
   logic [8:0]          dofs_rx;
   logic                mw_ok;
   logic                mw_lo;
   logic [15:0]         mw_word;
   logic [8:0]          dofs;
   logic [15:0]         word_ix;
   logic [15:0]         ram_rd;
   logic [15:0]         ireg_w;
   logic [15:0]         reg_word;
   logic [7:0]          reg_byte;
   logic [7:0]          bit_byte;
   logic [7:0]          tx_byte;
   logic                one_wr;
   logic                ram_we;
   logic [15:0]         ram_addr;
   logic [15:0]         ram_wdata;
   logic                tx_load;
   logic                tx_done;

   // Handshake and port check
   assign o_rx_ready = st_ff == mth_pkg::ST_RX;
   assign rx_fire    = i_rx_valid && o_rx_ready && i_ce;
   assign port_now   = (rx_cnt_ff == mth_pkg::IDX_FC) ?
                       (i_dst_port == mth_pkg::SERVICE_PORT) : port_ok_ff;

   // Function decode on the first byte
   assign fc       = req_ff.fc;
   assign is_bit   = (fc == mth_pkg::FC_RD_COIL) || (fc == mth_pkg::FC_RD_DIN);
   assign is_rreg  = (fc == mth_pkg::FC_RD_HREG) || (fc == mth_pkg::FC_RD_IREG);
   assign is_one   = fc == mth_pkg::FC_WR_ONE;
   assign is_multi = fc == mth_pkg::FC_WR_MULTI;
   assign known    = is_bit || is_rreg || is_one || is_multi;
   assign bit_lim  = (fc == mth_pkg::FC_RD_COIL) ? mth_pkg::COIL_N : mth_pkg::DIN_N;
   assign reg_lim  = (fc == mth_pkg::FC_RD_HREG) ? mth_pkg::HREG_N : mth_pkg::IREG_N;

   // Quantity and length checks
   assign qty_zero = req_ff.qty == 16'h0000;
   assign qty2     = {req_ff.qty[14:0], 1'b0};
   assign len_bad  = is_multi ?
                     (rx_cnt_ff != mth_pkg::IDX_DATA + {1'b0, req_ff.bcnt}) :
                     (rx_cnt_ff != mth_pkg::ECHO_LEN);
   assign bad_qty  = len_bad
                   || (is_bit && (qty_zero || req_ff.qty > mth_pkg::BIT_QTY_MAX))
                   || (is_rreg && (qty_zero || req_ff.qty > mth_pkg::REG_QTY_MAX))
                   || (is_multi && (qty_zero || req_ff.qty > mth_pkg::WR_QTY_MAX
                                   || {8'h00, req_ff.bcnt} != qty2));

   // Range check over every addressed item
   assign bad_addr = is_bit  ? !in_range(req_ff.addr, req_ff.qty, bit_lim) :
                     is_rreg ? !in_range(req_ff.addr, req_ff.qty, reg_lim) :
                     is_one  ? !in_range(req_ff.addr, 16'h0001, mth_pkg::HREG_N) :
                               !in_range(req_ff.addr, req_ff.qty, mth_pkg::HREG_N);

   // Exception priority: function, then value, then address
   assign exc_nxt = !known  ? mth_pkg::EXC_FUNC :
                    bad_qty ? mth_pkg::EXC_VALUE :
                    bad_addr ? mth_pkg::EXC_ADDR : mth_pkg::EXC_NONE;

   // Response length
   assign bcnt_w  = (req_ff.qty + 16'h0007) >> 3;
   assign len_nxt = (exc_nxt != mth_pkg::EXC_NONE) ? mth_pkg::RSP_HDR :
                    is_bit  ? mth_pkg::RSP_HDR + bcnt_w[8:0] :
                    is_rreg ? mth_pkg::RSP_HDR + {req_ff.qty[7:0], 1'b0} :
                              mth_pkg::ECHO_LEN;

   // Multiple write: words stored as their low bytes arrive
   assign dofs_rx = rx_cnt_ff - mth_pkg::IDX_DATA;
   assign mw_ok   = is_multi && rx_cnt_ff >= mth_pkg::IDX_DATA
                    && !qty_zero && req_ff.qty <= mth_pkg::WR_QTY_MAX
                    && {8'h00, req_ff.bcnt} == qty2
                    && in_range(req_ff.addr, req_ff.qty, mth_pkg::HREG_N)
                    && port_ok_ff;
   assign mw_lo   = dofs_rx[0] && ({8'h00, dofs_rx[8:1]} < req_ff.qty);
   assign mw_word = req_ff.addr + {8'h00, dofs_rx[8:1]};

   // Single write commits once the request checks clean
   assign one_wr  = st_ff == mth_pkg::ST_EXEC && is_one && exc_nxt == mth_pkg::EXC_NONE;

   // Store port shared by writes and response reads
   assign ram_we    = (rx_fire && mw_ok && mw_lo) || one_wr;
   assign ram_addr  = (st_ff == mth_pkg::ST_RX) ? mw_word :
                      (st_ff == mth_pkg::ST_EXEC) ? req_ff.addr : word_ix;
   assign ram_wdata = (st_ff == mth_pkg::ST_RX) ? {wr_hi_ff, i_rx.data} : req_ff.qty;

   mth_word_ram u_ram (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_ce      (i_ce),
      .i_we      (ram_we),
      .i_addr    (ram_addr[mth_pkg::HREG_AW-1:0]),
      .i_wdata   (ram_wdata),
      .o_rdata   (ram_rd)
   );

   // Payload words and bytes for the next response byte
   assign dofs     = bi_ff - mth_pkg::RSP_HDR;
   assign word_ix  = req_ff.addr + {8'h00, dofs[8:1]};
   assign ireg_w   = i_ireg_img[{word_ix[2:0], 4'h0} +: 16];
   assign reg_word = (fc == mth_pkg::FC_RD_HREG) ? ram_rd : ireg_w;
   assign reg_byte = dofs[0] ? reg_word[7:0] : reg_word[15:8];
   assign bit_byte = pack_bits((fc == mth_pkg::FC_RD_COIL) ? i_coil_img : i_din_img,
                               req_ff.addr, dofs, req_ff.qty);

   // Response byte select
   always_comb begin
      tx_byte = 8'h00;
      if (bi_ff == mth_pkg::IDX_FC) begin
         tx_byte = (exc_ff != mth_pkg::EXC_NONE) ? (fc + mth_pkg::ERR_FLAG) : fc;
      end else if (exc_ff != mth_pkg::EXC_NONE) begin
         tx_byte = exc_ff;
      end else if (is_bit) begin
         tx_byte = (bi_ff == mth_pkg::IDX_ADR_HI) ? bcnt_w[7:0] : bit_byte;
      end else if (is_rreg) begin
         tx_byte = (bi_ff == mth_pkg::IDX_ADR_HI) ? qty2[7:0] : reg_byte;
      end else if (bi_ff == mth_pkg::IDX_ADR_HI) begin
         tx_byte = req_ff.addr[15:8];
      end else if (bi_ff == mth_pkg::IDX_ADR_LO) begin
         tx_byte = req_ff.addr[7:0];
      end else if (bi_ff == mth_pkg::IDX_QTY_HI) begin
         tx_byte = req_ff.qty[15:8];
      end else begin
         tx_byte = req_ff.qty[7:0];
      end
   end

   // Send pacing: a bubble after each byte lets the store catch up
   assign tx_load = st_ff == mth_pkg::ST_TX && !wait_ff && bi_ff < len_ff
                    && (!tx_vld_ff || i_tx_ready);
   assign tx_done = tx_vld_ff && i_tx_ready && bi_ff == len_ff;

   // Sequencer: answers only follow a received request
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         mth_pkg::ST_RX: begin
            if (rx_fire && i_rx.last && port_now) begin
               nxt_st = mth_pkg::ST_EXEC;
            end
         end
         mth_pkg::ST_EXEC: begin
            nxt_st = mth_pkg::ST_TX;
         end
         mth_pkg::ST_TX: begin
            if (tx_done) begin
               nxt_st = mth_pkg::ST_RX;
            end
         end
         default: begin
            nxt_st = mth_pkg::ST_RX;
         end
      endcase
   end

   // State and request byte counter
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff     <= mth_pkg::ST_RX;
         rx_cnt_ff <= 9'h000;
      end else if (i_ce) begin
         st_ff <= nxt_st;
         if (tx_done || (rx_fire && i_rx.last && !port_now)) begin
            rx_cnt_ff <= 9'h000;
         end else if (rx_fire && rx_cnt_ff != mth_pkg::CNT_MAX) begin
            rx_cnt_ff <= rx_cnt_ff + 9'h001;
         end
      end
   end

   // Header capture, high byte first
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         req_ff     <= '0;
         port_ok_ff <= 1'b0;
         wr_hi_ff   <= 8'h00;
      end else if (rx_fire) begin
         port_ok_ff <= port_now;
         if (rx_cnt_ff == mth_pkg::IDX_FC)     req_ff.fc         <= i_rx.data;
         if (rx_cnt_ff == mth_pkg::IDX_ADR_HI) req_ff.addr[15:8] <= i_rx.data;
         if (rx_cnt_ff == mth_pkg::IDX_ADR_LO) req_ff.addr[7:0]  <= i_rx.data;
         if (rx_cnt_ff == mth_pkg::IDX_QTY_HI) req_ff.qty[15:8]  <= i_rx.data;
         if (rx_cnt_ff == mth_pkg::IDX_QTY_LO) req_ff.qty[7:0]   <= i_rx.data;
         if (rx_cnt_ff == mth_pkg::IDX_BCNT)   req_ff.bcnt       <= i_rx.data;
         if (!dofs_rx[0])                      wr_hi_ff          <= i_rx.data;
      end
   end

   // Send control
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bi_ff     <= 9'h000;
         wait_ff   <= 1'b0;
         tx_vld_ff <= 1'b0;
      end else if (i_ce) begin
         wait_ff <= tx_load || st_ff == mth_pkg::ST_EXEC;
         if (st_ff == mth_pkg::ST_EXEC) begin
            bi_ff <= 9'h000;
         end else if (tx_load) begin
            bi_ff     <= bi_ff + 9'h001;
            tx_vld_ff <= 1'b1;
         end else if (tx_vld_ff && i_tx_ready) begin
            tx_vld_ff <= 1'b0;
         end
      end
   end

   // Send data and verdict
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_ff     <= '0;
         tx_idx_ff <= 9'h000;
         exc_ff    <= mth_pkg::EXC_NONE;
         len_ff    <= 9'h000;
      end else if (i_ce) begin
         if (st_ff == mth_pkg::ST_EXEC) begin
            exc_ff <= exc_nxt;
            len_ff <= len_nxt;
         end
         if (tx_load) begin
            tx_ff.data <= tx_byte;
            tx_ff.last <= bi_ff == len_ff - 9'h001;
            tx_idx_ff  <= bi_ff;
         end
      end
   end

   assign o_tx       = tx_ff;
   assign o_tx_valid = tx_vld_ff;

   // Checks on the response stream
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   a_fc_echo: assert property (
      tx_vld_ff && tx_idx_ff == 9'h000 && exc_ff == mth_pkg::EXC_NONE
      |-> tx_ff.data == fc)
      else $error("response does not open with the function code");

   a_err_head: assert property (
      tx_vld_ff && tx_idx_ff == 9'h000 && exc_ff != mth_pkg::EXC_NONE
      |-> tx_ff.data == (fc + mth_pkg::ERR_FLAG) && len_ff == mth_pkg::RSP_HDR)
      else $error("error frame head wrong");

   a_err_tail: assert property (
      tx_vld_ff && tx_idx_ff == 9'h001 && exc_ff != mth_pkg::EXC_NONE
      |-> tx_ff.last && tx_ff.data == exc_ff)
      else $error("error frame tail wrong");

   a_server_only: assert property (
      tx_vld_ff |-> st_ff == mth_pkg::ST_TX && !o_rx_ready)
      else $error("response outside a transaction");

   a_port_filter: assert property (
      rx_fire && i_rx.last && !port_now |=> st_ff == mth_pkg::ST_RX && rx_cnt_ff == 9'h000)
      else $error("request to foreign port served");

   a_bit_count: assert property (
      tx_vld_ff && tx_idx_ff == 9'h001 && exc_ff == mth_pkg::EXC_NONE && is_bit
      |-> tx_ff.data == bcnt_w[7:0])
      else $error("bit read byte count wrong");

   a_reg_count: assert property (
      tx_vld_ff && tx_idx_ff == 9'h001 && exc_ff == mth_pkg::EXC_NONE && is_rreg
      |-> tx_ff.data == qty2[7:0] && len_ff == mth_pkg::RSP_HDR + qty2[8:0])
      else $error("register read byte count wrong");

   a_pad_zero: assert property (
      tx_vld_ff && is_bit && exc_ff == mth_pkg::EXC_NONE && tx_ff.last
      && req_ff.qty[2:0] != 3'h0 |-> (tx_ff.data >> req_ff.qty[2:0]) == 8'h00)
      else $error("padding bits not zero");

   a_qty_range: assert property (
      st_ff == mth_pkg::ST_EXEC && i_ce && is_bit && req_ff.qty > mth_pkg::BIT_QTY_MAX
      |=> exc_ff == mth_pkg::EXC_VALUE)
      else $error("oversized bit quantity accepted");

   a_bad_func: assert property (
      st_ff == mth_pkg::ST_EXEC && i_ce && !known |=> exc_ff == mth_pkg::EXC_FUNC)
      else $error("unknown function not refused");

   c_bit_read: cover property (tx_done && is_bit && exc_ff == mth_pkg::EXC_NONE);
   c_reg_read: cover property (tx_done && is_rreg && exc_ff == mth_pkg::EXC_NONE);
   c_multi_wr: cover property (tx_done && is_multi && exc_ff == mth_pkg::EXC_NONE);
   c_err_frame: cover property (tx_done && exc_ff == mth_pkg::EXC_ADDR);

endmodule

// file: hdl/mth_pkg.sv
// Constants and carrier types for the Modbus request PDU handler
package mth_pkg;

   // Function codes served
   localparam logic [7:0] FC_RD_COIL  = 8'h01;
   localparam logic [7:0] FC_RD_DIN   = 8'h02;
   localparam logic [7:0] FC_RD_HREG  = 8'h03;
   localparam logic [7:0] FC_RD_IREG  = 8'h04;
   localparam logic [7:0] FC_WR_ONE   = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   localparam logic [7:0] ERR_FLAG    = 8'h80;

   // Exception codes
   localparam logic [7:0] EXC_NONE  = 8'h00;
   localparam logic [7:0] EXC_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ADDR  = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;

   // Quantity limits
   localparam logic [15:0] BIT_QTY_MAX = 16'h07D0;
   localparam logic [15:0] REG_QTY_MAX = 16'h007D;
   localparam logic [15:0] WR_QTY_MAX  = 16'h007B;

   // Listening service port
   localparam logic [15:0] SERVICE_PORT = 16'h01F6;

   // Image sizes
   localparam int          BIT_W   = 32;
   localparam int          IREG_W  = 8;
   localparam int          HREG_AW = 6;
   localparam logic [16:0] COIL_N  = 17'(BIT_W);
   localparam logic [16:0] DIN_N   = 17'(BIT_W);
   localparam logic [16:0] IREG_N  = 17'(IREG_W);
   localparam logic [16:0] HREG_N  = 17'(1 << HREG_AW);

   // Byte positions and lengths
   localparam logic [8:0] IDX_FC     = 9'h000;
   localparam logic [8:0] IDX_ADR_HI = 9'h001;
   localparam logic [8:0] IDX_ADR_LO = 9'h002;
   localparam logic [8:0] IDX_QTY_HI = 9'h003;
   localparam logic [8:0] IDX_QTY_LO = 9'h004;
   localparam logic [8:0] IDX_BCNT   = 9'h005;
   localparam logic [8:0] IDX_DATA   = 9'h006;
   localparam logic [8:0] RSP_HDR    = 9'h002;
   localparam logic [8:0] ECHO_LEN   = 9'h005;
   localparam logic [8:0] CNT_MAX    = 9'h1FF;

   // One byte of a PDU stream
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } mth_beat_t;

   // Decoded request header
   typedef struct packed {
      logic [7:0]  fc;
      logic [15:0] addr;
      logic [15:0] qty;
      logic [7:0]  bcnt;
   } mth_req_t;

   typedef enum logic [2:0] {
      ST_RX   = 3'b001,
      ST_EXEC = 3'b010,
      ST_TX   = 3'b100
   } mth_state_t;

endpackage

// file: hdl/mth_word_ram.sv
// Marker word store with registered read data
`timescale 1ns/10ps
module mth_word_ram (
   input  wire logic                        i_sys_clk,  // System clock
   input  wire logic                        i_nrst,     // Async reset, low
   input  wire logic                        i_ce,       // Clock enable
   input  wire logic                        i_we,       // Write strobe
   input  wire logic [mth_pkg::HREG_AW-1:0] i_addr,     // Word address
   input  wire logic [15:0]                 i_wdata,    // Write word
   output logic      [15:0]                 o_rdata     // Read word
);
   logic [15:0] mem [0:(1 << mth_pkg::HREG_AW)-1];
   logic [15:0] rdata_ff;

   // Storage write
   always_ff @(posedge i_sys_clk) begin
      if (i_ce && i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   // Read port, one cycle late
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_ff <= 16'h0000;
      end else if (i_ce) begin
         rdata_ff <= mem[i_addr];
      end
   end

   assign o_rdata = rdata_ff;
endmodule

// file: dv/mth_client.sv
// Client model: offers request PDUs and collects response PDUs
`timescale 1ns/10ps
module mth_client (
   input  wire logic               i_sys_clk,  // Clock
   input  wire logic               i_rx_ready, // Server takes a byte
   input  wire mth_pkg::mth_beat_t i_tx,       // Response byte
   input  wire logic               i_tx_valid, // Response byte valid
   output mth_pkg::mth_beat_t      o_rx,       // Request byte
   output logic                    o_rx_valid, // Request byte valid
   output logic [15:0]             o_dst_port, // Target port
   output logic                    o_tx_ready  // Response byte taken
);
   logic slow  = 1'b0; // Sink stalls every other cycle
   logic stuck = 1'b0; // A request byte was never taken

   // Idle levels before any request
   initial begin
      o_rx       = '0;
      o_rx_valid = 1'b0;
      o_dst_port = 16'h01F6;
      o_tx_ready = 1'b1;
   end

   // Offer each byte, function code first, and hold it until taken or 50 cycles pass
   task automatic send(input logic [15:0] port, input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++) begin
         @(negedge i_sys_clk);
         o_dst_port = port;
         o_rx       = '{data: b[i], last: (i == b.size() - 1)};
         o_rx_valid = 1'b1;
         for (int t = 0; t < 50 && i_rx_ready !== 1'b1; t++) @(negedge i_sys_clk);
         if (i_rx_ready !== 1'b1) stuck = 1'b1;
         @(posedge i_sys_clk);
      end
      // Released data shows the inverse so stale bytes cannot pass
      @(negedge i_sys_clk);
      o_rx_valid = 1'b0;
      o_rx.data  = ~o_rx.data;
   endtask

   // Take response bytes until the last one, stalling when slow
   task automatic recv(output logic [7:0] b[$], output logic ok);
      b  = {};
      ok = 1'b0;
      for (int t = 0; t < 400 && !ok; t++) begin
         @(negedge i_sys_clk);
         o_tx_ready = slow ? t[0] : 1'b1;
         if (o_tx_ready && i_tx_valid === 1'b1) begin
            b.push_back(i_tx.data);
            ok = i_tx.last;
         end
      end
   endtask
endmodule

// file: dv/tb_top.sv
// Testbench: request and response scenarios for the PDU handler
`timescale 1ns/10ps
module tb_top;
   logic               i_sys_clk = 1'b0;
   logic               i_nrst    = 1'b0;
   logic               i_ce      = 1'b1;
   mth_pkg::mth_beat_t rx;
   mth_pkg::mth_beat_t tx;
   logic               rx_valid;
   logic               rx_ready;
   logic               tx_valid;
   logic               tx_ready;
   logic [15:0]        port;
   logic [31:0]        coil = 32'hA5C3_0F96;
   logic [31:0]        din  = 32'h3C5A_81E7;
   logic [127:0]       ireg = 128'h0123_4567_89AB_CDEF_1357_9BDF_2468_ACE0;
   int                 errors = 0;
   int                 comparisons = 0;

   // Clock, 50 ns period
   always #25 i_sys_clk = ~i_sys_clk;

   mth_pdu_handler dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_rx(rx),
      .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_dst_port(port), .o_tx(tx),
      .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_coil_img(coil), .i_din_img(din),
      .i_ireg_img(ireg));

   mth_client cli (.i_sys_clk(i_sys_clk), .i_rx_ready(rx_ready), .i_tx(tx),
      .i_tx_valid(tx_valid), .o_rx(rx), .o_rx_valid(rx_valid), .o_dst_port(port),
      .o_tx_ready(tx_ready));

   // Verdict and end of run
   task automatic final_report();
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One transaction: send, collect, compare byte by byte
   task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$]);
      logic [7:0] got[$];
      logic       ok;
      cli.send(16'h01F6, req);
      chk("request taken", 8'h00, {7'h00, cli.stuck});
      if (cli.stuck) final_report();
      cli.recv(got, ok);
      chk("response done", 8'h01, {7'h00, ok});
      if (!ok) final_report();
      chk("response length", 8'(exp.size()), 8'(got.size()));
      foreach (exp[i]) chk("response byte", exp[i], (i < got.size()) ? got[i] : 8'hXX);
   endtask

   // Expected byte count and packed states, first item in bit 0, pad zero
   task automatic bits(input logic [31:0] img, input int st, input int n,
                       inout logic [7:0] q[$]);
      logic [7:0] b;
      q.push_back(8'((n + 7) / 8));
      for (int k = 0; k < (n + 7) / 8; k++) begin
         b = 8'h00;
         for (int j = 0; j < 8; j++) if (8 * k + j < n) b[j] = img[st + 8 * k + j];
         q.push_back(b);
      end
   endtask

   // Wrong port is swallowed and nothing is sent unasked
   task automatic sc_port();
      logic seen = 1'b0;
      cli.send(16'h01F7, {8'h01, 8'h00, 8'h00, 8'h00, 8'h01});
      for (int t = 0; t < 20; t++) begin
         @(negedge i_sys_clk);
         if (tx_valid !== 1'b0 || rx_ready !== 1'b1) seen = 1'b1;
      end
      chk("unasked response", 8'h00, {7'h00, seen});
   endtask

   task automatic sc_coils();
      logic [7:0] e[$] = {8'h01};
      bits(coil, 3, 10, e);
      run({8'h01, 8'h00, 8'h03, 8'h00, 8'h0A}, e);
   endtask

   task automatic sc_din();
      logic [7:0] e[$] = {8'h02};
      bits(din, 0, 32, e);
      cli.slow = 1'b1;
      run({8'h02, 8'h00, 8'h00, 8'h00, 8'h20}, e);
      cli.slow = 1'b0;
   endtask

   task automatic sc_ireg();
      run({8'h04, 8'h00, 8'h06, 8'h00, 8'h02}, {8'h04, 8'h04, ireg[111:104], ireg[103:96],
          ireg[127:120], ireg[119:112]});
   endtask

   // Writes land in the marker words; a foreign port write must not
   task automatic sc_writes();
      run({8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, {8'h06, 8'h00, 8'h05, 8'h12, 8'h34});
      run({8'h10, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h04, 8'hAB, 8'hCD, 8'h00, 8'hEF},
          {8'h10, 8'h00, 8'h0A, 8'h00, 8'h02});
      run({8'h03, 8'h00, 8'h0A, 8'h00, 8'h02}, {8'h03, 8'h04, 8'hAB, 8'hCD, 8'h00, 8'hEF});
      run({8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, {8'h03, 8'h02, 8'h12, 8'h34});
      cli.send(16'h01F7, {8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'hFF, 8'hFF});
      run({8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, {8'h03, 8'h02, 8'h12, 8'h34});
   endtask

   task automatic sc_errors();
      run({8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h87, 8'h01});
      run({8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h81, 8'h03});
      run({8'h02, 8'h00, 8'h00, 8'h07, 8'hD1}, {8'h82, 8'h03});
      run({8'h01, 8'h00, 8'h1F, 8'h00, 8'h02}, {8'h81, 8'h02});
      run({8'h03, 8'h00, 8'h00, 8'h00, 8'h7E}, {8'h83, 8'h03});
      run({8'h04, 8'h00, 8'h07, 8'h00, 8'h02}, {8'h84, 8'h02});
      run({8'h06, 8'h00, 8'h40, 8'h00, 8'h01}, {8'h86, 8'h02});
      run({8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h11, 8'h22}, {8'h90, 8'h03});
   endtask

   // Clock enable low holds the handler still between request and response
   task automatic sc_freeze();
      logic [7:0] got[$];
      logic       ok;
      logic       moved = 1'b0;
      cli.send(16'h01F6, {8'h04, 8'h00, 8'h00, 8'h00, 8'h01});
      i_ce = 1'b0;
      for (int t = 0; t < 10; t++) begin
         @(negedge i_sys_clk);
         if (tx_valid !== 1'b0 || rx_ready !== 1'b0) moved = 1'b1;
      end
      i_ce = 1'b1;
      cli.recv(got, ok);
      chk("frozen handler", 8'h00, {7'h00, moved});
      chk("response done", 8'h01, {7'h00, ok});
      if (!ok) final_report();
      chk("response length", 8'h04, 8'(got.size()));
      chk("response byte", 8'h04, got[0]);
      chk("response byte", 8'h02, got[1]);
      chk("response byte", ireg[15:8], got[2]);
      chk("response byte", ireg[7:0], got[3]);
   endtask

   // Reset for 4 cycles, then the scenarios
   initial begin
      repeat (4) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_nrst = 1'b1;
      sc_port();
      sc_coils();
      sc_din();
      sc_ireg();
      sc_writes();
      sc_errors();
      sc_freeze();
      chk("request taken", 8'h00, {7'h00, cli.stuck});
      final_report();
   end
endmodule
